// ### hw/pmes_defs.vh
`ifndef PMES_DEFS_VH
`define PMES_DEFS_VH
// ******************************************
// register word addresses on the dcr bus
// ******************************************
`define PMES_AW 10
`define PMES_A_CFG 10'h054
`define PMES_A_EADDR_HI 10'h056
`define PMES_A_EADDR_LO 10'h057
`define PMES_A_ESTAT 10'h058
`define PMES_A_QFLAGS 10'h059
`define PMES_A_IRQ 10'h05a
`define PMES_A_FSM 10'h05b
`define PMES_A_MCTRL 10'h05c
`define PMES_A_SNIFF 10'h05d
`define PMES_A_SNIFFA 10'h05e
// ******************************************
// reset values
// ******************************************
`define PMES_CFG_RST 32'h8000009f
`define PMES_ZERO32 32'h00000000
// ******************************************
// field positions, lsb numbering (msb is bit 0 in the register maps)
// ******************************************
`define PMES_CFG_LOCK 31
`define PMES_CFG_WPOST 1
`define PMES_IRQ_W 13
`define PMES_QF_W 6
`define PMES_QC_W 7
`define PMES_MC_FLUSH_HI 30
`define PMES_MC_FLUSH_LO 29
`define PMES_MC_RSV3 28
`define PMES_MC_QCLR_HI 6
`define PMES_SN_ENABLE 31
`define PMES_SN_SIZE_HI 27
`define PMES_SN_SIZE_LO 24
`define PMES_SN_RNW 23
`define PMES_SN_MID_HI 22
`define PMES_SN_MID_LO 20
`define PMES_SN_SRC 19
`define PMES_SN_FMID_HI 17
`define PMES_SN_FMID_LO 16
`define PMES_SN_SSIZE_HI 15
`define PMES_SN_SSIZE_LO 14
`define PMES_SN_SIZE_EN 6
`define PMES_SN_DIR_EN 5
`define PMES_SN_MID_EN 4
`define PMES_SN_SRC_EN 3
`define PMES_SN_FMID_EN 2
`define PMES_SN_SSIZE_EN 1
`define PMES_SN_ADDR_EN 0
`define PMES_SN_MASK 32'h8ffbc07f
`define PMES_ES_VLD 31
// ******************************************
// requester codes and one-hot status patterns
// ******************************************
`define PMES_MID_INSTR_READ_PORT 3'h0
`define PMES_MID_DATA_WRITE_PORT 3'h1
`define PMES_MID_DATA_READ_PORT 3'h2
`define PMES_MID_SP0 3'h3
`define PMES_MID_SP1 3'h4
`define PMES_IRQ_DMA0 13'h1000
`define PMES_IRQ_DMA1 13'h0800
`define PMES_IRQ_INSTR_READ_PORT 13'h0400
`define PMES_IRQ_DATA_WRITE_PORT 13'h0200
`define PMES_IRQ_DATA_READ_PORT 13'h0100
`define PMES_IRQ_SP0_M0 13'h0080
`define PMES_IRQ_SP1_M0 13'h0008
`endif

// ### hw/pmes_sniff_cmp.v
`timescale 1ns/1ps
`include "pmes_defs.vh"
// ******************************************
// command sniffer qualifier comparison
// ******************************************
module pmes_sniff_cmp (
  input wire [31:0] match_i,
  input wire [31:0] addr_i,
  input wire [3:0] txn_size_i,
  input wire txn_rnw_i,
  input wire [2:0] txn_mid_i,
  input wire txn_slave_port_i,
  input wire [1:0] txn_fmid_i,
  input wire [1:0] txn_ssize_i,
  input wire [35:0] txn_addr_i,
  output wire hit_o
);
  wire size_ok;
  wire dir_ok;
  wire mid_ok;
  wire src_ok;
  wire fmid_ok;
  wire ssize_ok;
  wire addr_ok;
  // a disabled qualifier always agrees
  assign size_ok = ~match_i[`PMES_SN_SIZE_EN] |
    (match_i[`PMES_SN_SIZE_HI:`PMES_SN_SIZE_LO] == txn_size_i);
  assign dir_ok = ~match_i[`PMES_SN_DIR_EN] | (match_i[`PMES_SN_RNW] == txn_rnw_i);
  assign mid_ok = ~match_i[`PMES_SN_MID_EN] |
    (match_i[`PMES_SN_MID_HI:`PMES_SN_MID_LO] == txn_mid_i);
  assign src_ok = ~match_i[`PMES_SN_SRC_EN] | (match_i[`PMES_SN_SRC] == txn_slave_port_i);
  assign fmid_ok = ~match_i[`PMES_SN_FMID_EN] |
    (match_i[`PMES_SN_FMID_HI:`PMES_SN_FMID_LO] == txn_fmid_i);
  assign ssize_ok = ~match_i[`PMES_SN_SSIZE_EN] |
    (match_i[`PMES_SN_SSIZE_HI:`PMES_SN_SSIZE_LO] == txn_ssize_i);
  // only the low word of the 36-bit address is compared
  assign addr_ok = ~match_i[`PMES_SN_ADDR_EN] | (addr_i == txn_addr_i[31:0]);
  assign hit_o = match_i[`PMES_SN_ENABLE] & size_ok & dir_ok & mid_ok & src_ok &
    fmid_ok & ssize_ok & addr_ok;
endmodule // pmes_sniff_cmp

// ### hw/pmes_regs.v
// Operation
// - mirq status bits come from slave mirq level or posted write errors.
// - slave mirq level sets all mirq bits; they follow it, read only.
// - posted write error sets one requester bit, cleared by writing one.
// - bits 19 and 20 flag write errors from dma on slave ports 0, 1.
// - bits 21-23 processor ports, 24-27 port0 masters, 28-31 port1 masters.
// - queue overflow and underflow events set sticky flags at bits 26-31.
// - each queue flag clears by writing one; zero leaves it.
// - queue interrupt output is high while any queue flag is set.
// - state machine register always reads zero.
// - write-only control bits always read zero.
// - flush mode 00 flushes on address ack time-out, 11 never flushes.
// - writing one to bits 25-31 pulses the matching queue resets, all in the same cycle.
// - sniffer captures only while its enable bit is one.
// - sniffer match loads error status and error address registers.
// - sniffer match fields hold size, direction, ids, source and slave size.
// - each qualifier compares only when its enable bit is one.
// - sniffer address holds low 32 address bits, compared when enabled.
// - with lock set, error status updates only while its valid bit is zero or in the cycle of a clearing write.
`timescale 1ns/1ps
`include "pmes_defs.vh"
module pmes_regs (
  input wire sys_clk_i,
  input wire reset_i,
  // dcr slave
  input wire dcr_rd_i,
  input wire dcr_wr_i,
  input wire [`PMES_AW-1:0] dcr_addr_i,
  input wire [31:0] dcr_wdata_i,
  output wire dcr_ack_o,
  output wire [31:0] dcr_rdata_o,
  // transaction observed on the master port
  input wire txn_valid_i,
  input wire [3:0] txn_size_i,
  input wire txn_rnw_i,
  input wire [2:0] txn_mid_i,
  input wire txn_slave_port_i,
  input wire [1:0] txn_fmid_i,
  input wire [1:0] txn_ssize_i,
  input wire [2:0] txn_type_i,
  input wire txn_lockerr_i,
  input wire [15:0] txn_be_i,
  input wire [35:0] txn_addr_i,
  // error events from the slave side
  input wire txn_err_i,
  input wire slave_mwr_err_i,
  input wire slave_mirq_i,
  input wire [`PMES_QF_W-1:0] queue_event_i,
  // control outputs
  output wire [1:0] flush_mode_o,
  output wire write_post_o,
  output wire [`PMES_QC_W-1:0] queue_clear_o,
  output wire xbar_queue_irq_o
);
  // ******************************************
  // helpers
  // ******************************************
  function [`PMES_IRQ_W-1:0] req_onehot;
    input [2:0] mid;
    input sp;
    input [1:0] fmid;
    begin
      case (mid)
        `PMES_MID_INSTR_READ_PORT: req_onehot = `PMES_IRQ_INSTR_READ_PORT;
        `PMES_MID_DATA_WRITE_PORT: req_onehot = `PMES_IRQ_DATA_WRITE_PORT;
        `PMES_MID_DATA_READ_PORT: req_onehot = `PMES_IRQ_DATA_READ_PORT;
        `PMES_MID_SP0: req_onehot = sp ? (`PMES_IRQ_SP0_M0 >> fmid) : `PMES_IRQ_DMA0;
        `PMES_MID_SP1: req_onehot = sp ? (`PMES_IRQ_SP1_M0 >> fmid) : `PMES_IRQ_DMA1;
        default: req_onehot = {`PMES_IRQ_W{1'b0}};
      endcase
    end
  endfunction

  function [31:0] status_word;
    input lockerr;
    input sp;
    input [2:0] mid;
    input [1:0] ssize;
    input [2:0] ttype;
    input rnw;
    input [3:0] size;
    input [15:0] be;
    begin
      status_word = {1'b1, lockerr, sp, mid, ssize, ttype, rnw, size, be};
    end
  endfunction

  // ******************************************
  // dcr access
  // ******************************************
  // ack one cycle after the strobe; the master drops its strobe after ack
  reg ack_q;
  reg [31:0] rdata_q;
  wire acc;
  wire wr_go;
  wire rd_go;
  assign acc = (dcr_rd_i | dcr_wr_i) & ~ack_q;
  assign wr_go = dcr_wr_i & ~ack_q;
  assign rd_go = dcr_rd_i & ~dcr_wr_i & ~ack_q;
  assign dcr_ack_o = ack_q;
  assign dcr_rdata_o = rdata_q;

  function wr_hit;
    input [`PMES_AW-1:0] a;
    input [`PMES_AW-1:0] target;
    begin
      wr_hit = (a == target);
    end
  endfunction

  wire wr_cfg;
  wire wr_eclr;
  wire wr_qf;
  wire wr_irq;
  wire wr_mc;
  wire wr_sn;
  wire wr_sna;
  assign wr_cfg = wr_go & wr_hit(dcr_addr_i, `PMES_A_CFG);
  // writing any of the three error capture registers clears all of them
  assign wr_eclr = wr_go & (wr_hit(dcr_addr_i, `PMES_A_ESTAT) |
    wr_hit(dcr_addr_i, `PMES_A_EADDR_HI) | wr_hit(dcr_addr_i, `PMES_A_EADDR_LO));
  assign wr_qf = wr_go & wr_hit(dcr_addr_i, `PMES_A_QFLAGS);
  assign wr_irq = wr_go & wr_hit(dcr_addr_i, `PMES_A_IRQ);
  assign wr_mc = wr_go & wr_hit(dcr_addr_i, `PMES_A_MCTRL);
  assign wr_sn = wr_go & wr_hit(dcr_addr_i, `PMES_A_SNIFF);
  assign wr_sna = wr_go & wr_hit(dcr_addr_i, `PMES_A_SNIFFA);

  // ******************************************
  // storage
  // ******************************************
  reg [31:0] cfg_q;
  reg [31:0] estat_q;
  reg [31:0] estat_d;
  reg [3:0] eaddr_hi_q;
  reg [3:0] eaddr_hi_d;
  reg [31:0] eaddr_lo_q;
  reg [31:0] eaddr_lo_d;
  reg [`PMES_QF_W-1:0] qf_q;
  reg [`PMES_IRQ_W-1:0] irq_q;
  reg [1:0] flush_q;
  reg rsv3_q;
  reg [`PMES_QC_W-1:0] qclr_q;
  reg [31:0] sniff_q;
  reg [31:0] sniffa_q;

  wire sniff_hit;
  wire cap_ev;
  wire cap_ok;
  wire [`PMES_IRQ_W-1:0] irq_set;
  wire [`PMES_IRQ_W-1:0] irq_view;

  pmes_sniff_cmp u_cmp (
    .match_i(sniff_q),
    .addr_i(sniffa_q),
    .txn_size_i(txn_size_i),
    .txn_rnw_i(txn_rnw_i),
    .txn_mid_i(txn_mid_i),
    .txn_slave_port_i(txn_slave_port_i),
    .txn_fmid_i(txn_fmid_i),
    .txn_ssize_i(txn_ssize_i),
    .txn_addr_i(txn_addr_i),
    .hit_o(sniff_hit)
  );

  // ******************************************
  // error and sniff capture
  // ******************************************
  assign cap_ev = txn_err_i | slave_mwr_err_i | (txn_valid_i & sniff_hit);
  // lock holds the first capture until software clears it
  assign cap_ok = ~cfg_q[`PMES_CFG_LOCK] | ~estat_q[`PMES_ES_VLD];

  always @* begin
    estat_d = estat_q;
    eaddr_hi_d = eaddr_hi_q;
    eaddr_lo_d = eaddr_lo_q;
    if (wr_eclr) begin
      estat_d = `PMES_ZERO32;
      eaddr_hi_d = 4'h0;
      eaddr_lo_d = `PMES_ZERO32;
    end
    // a capture in the clearing cycle wins over the clear
    if (cap_ev & (cap_ok | wr_eclr)) begin
      estat_d = status_word(txn_lockerr_i, txn_slave_port_i, txn_mid_i, txn_ssize_i,
        txn_type_i, txn_rnw_i, txn_size_i, txn_be_i);
      eaddr_hi_d = txn_addr_i[35:32];
      eaddr_lo_d = txn_addr_i[31:0];
    end
  end

  // ******************************************
  // mirq status
  // ******************************************
  assign irq_set = (slave_mwr_err_i & cfg_q[`PMES_CFG_WPOST]) ?
    req_onehot(txn_mid_i, txn_slave_port_i, txn_fmid_i) : {`PMES_IRQ_W{1'b0}};
  // the slave level is shown directly, so it clears when the slave clears
  assign irq_view = irq_q | {`PMES_IRQ_W{slave_mirq_i}};

  // ******************************************
  // registers
  // ******************************************
  always @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      ack_q <= 1'b0;
      rdata_q <= `PMES_ZERO32;
      cfg_q <= `PMES_CFG_RST;
      estat_q <= `PMES_ZERO32;
      eaddr_hi_q <= 4'h0;
      eaddr_lo_q <= `PMES_ZERO32;
      qf_q <= {`PMES_QF_W{1'b0}};
      irq_q <= {`PMES_IRQ_W{1'b0}};
      flush_q <= 2'h0;
      rsv3_q <= 1'b0;
      qclr_q <= {`PMES_QC_W{1'b0}};
      sniff_q <= `PMES_ZERO32;
      sniffa_q <= `PMES_ZERO32;
    end else begin
      ack_q <= acc;
      estat_q <= estat_d;
      eaddr_hi_q <= eaddr_hi_d;
      eaddr_lo_q <= eaddr_lo_d;
      if (wr_cfg) begin
        cfg_q <= dcr_wdata_i;
      end
      // set wins over a write-one clear in the same cycle
      qf_q <= (qf_q & ~(wr_qf ? dcr_wdata_i[`PMES_QF_W-1:0] : {`PMES_QF_W{1'b0}})) |
        queue_event_i;
      irq_q <= (irq_q & ~(wr_irq ? dcr_wdata_i[`PMES_IRQ_W-1:0] : {`PMES_IRQ_W{1'b0}})) |
        irq_set;
      if (wr_mc) begin
        flush_q <= dcr_wdata_i[`PMES_MC_FLUSH_HI:`PMES_MC_FLUSH_LO];
        rsv3_q <= dcr_wdata_i[`PMES_MC_RSV3];
      end
      // one-cycle clear pulses, bit 25 (rd data) at the top down to bit 31 (cmd)
      qclr_q <= wr_mc ? dcr_wdata_i[`PMES_MC_QCLR_HI:0] : {`PMES_QC_W{1'b0}};
      if (wr_sn) begin
        sniff_q <= dcr_wdata_i & `PMES_SN_MASK;
      end
      if (wr_sna) begin
        sniffa_q <= dcr_wdata_i;
      end
      if (rd_go) begin
        case (dcr_addr_i)
          `PMES_A_CFG: rdata_q <= cfg_q;
          `PMES_A_EADDR_HI: rdata_q <= {28'h0000000, eaddr_hi_q};
          `PMES_A_EADDR_LO: rdata_q <= eaddr_lo_q;
          `PMES_A_ESTAT: rdata_q <= estat_q;
          `PMES_A_QFLAGS: rdata_q <= {26'h0000000, qf_q};
          `PMES_A_IRQ: rdata_q <= {19'h00000, irq_view};
          `PMES_A_FSM: rdata_q <= `PMES_ZERO32;
          `PMES_A_MCTRL: rdata_q <= {1'b0, flush_q, rsv3_q, 28'h0000000};
          `PMES_A_SNIFF: rdata_q <= sniff_q;
          `PMES_A_SNIFFA: rdata_q <= sniffa_q;
          default: rdata_q <= `PMES_ZERO32;
        endcase
      end
    end
  end

  // ******************************************
  // outputs
  // ******************************************
  // reserved codes 01 and 10 pass through unchanged; software must avoid them
  assign flush_mode_o = flush_q;
  assign write_post_o = cfg_q[`PMES_CFG_WPOST];
  assign queue_clear_o = qclr_q;
  assign xbar_queue_irq_o = |qf_q;
endmodule // pmes_regs

// ### tb/pmes_regs_assertions.sv
`timescale 1ns/1ps
`include "pmes_defs.vh"
// ******************************************
// dcr handshake and control output checks
// ******************************************
module pmes_regs_chk (
  input wire sys_clk_i,
  input wire reset_i,
  input wire dcr_rd_i,
  input wire dcr_wr_i,
  input wire [`PMES_AW-1:0] dcr_addr_i,
  input wire [31:0] dcr_wdata_i,
  input wire dcr_ack_o,
  input wire [31:0] dcr_rdata_o,
  input wire slave_mirq_i,
  input wire [5:0] queue_event_i,
  input wire [1:0] flush_mode_o,
  input wire [6:0] queue_clear_o,
  input wire xbar_queue_irq_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);
  // a strobe seen while ack is low is a new access
  wire take = (dcr_rd_i | dcr_wr_i) & ~dcr_ack_o;
  wire rd_take = take & ~dcr_wr_i;
  wire mc_wr = take & dcr_wr_i & (dcr_addr_i == `PMES_A_MCTRL);
  a_ack_follows_req: assert property (take |=> dcr_ack_o) else $error("ack missing");
  a_ack_one_cycle: assert property (dcr_ack_o |=> !dcr_ack_o) else $error("ack too long");
  a_qclr_copies_write: assert property (
    mc_wr |=> queue_clear_o == $past(dcr_wdata_i[6:0])) else $error("queue clear pulse wrong");
  a_qclr_single_pulse: assert property (
    queue_clear_o != 7'h00 |=> queue_clear_o == 7'h00) else $error("queue clear not a pulse");
  a_flush_takes_write: assert property (
    mc_wr |=> flush_mode_o == $past(dcr_wdata_i[30:29])) else $error("flush mode not written");
  a_qirq_on_event: assert property (queue_event_i != 6'h00 |=> xbar_queue_irq_o)
    else $error("queue irq missing");
  a_fsm_reads_zero: assert property (
    rd_take && dcr_addr_i == `PMES_A_FSM |=> dcr_rdata_o == 32'h0)
    else $error("state register not zero");
  a_wo_bits_zero: assert property (
    rd_take && dcr_addr_i == `PMES_A_MCTRL |=> {dcr_rdata_o[31], dcr_rdata_o[6:0]} == 8'h00)
    else $error("write-only bits not zero");
  a_mirq_level_all: assert property (
    rd_take && dcr_addr_i == `PMES_A_IRQ && slave_mirq_i && $past(slave_mirq_i)
    |=> dcr_rdata_o[12:0] == 13'h1fff) else $error("mirq level not on all bits");
endmodule // pmes_regs_chk

bind pmes_regs pmes_regs_chk i_chk (.sys_clk_i, .reset_i, .dcr_rd_i, .dcr_wr_i, .dcr_addr_i,
  .dcr_wdata_i, .dcr_ack_o, .dcr_rdata_o, .slave_mirq_i, .queue_event_i, .flush_mode_o,
  .queue_clear_o, .xbar_queue_irq_o);

// ### tb/pmes_slave_model.sv
`timescale 1ns/1ps
// ******************************************
// far side: slave error events and command qualifiers
// ******************************************
module pmes_slave_model (
  input wire sys_clk_i,
  output reg txn_valid_o,
  output reg txn_err_o,
  output reg mwr_err_o,
  output reg mirq_o,
  output reg [12:0] qual_o,
  output reg [35:0] addr_o
);
  initial {txn_valid_o, txn_err_o, mwr_err_o, mirq_o, qual_o, addr_o} = 53'h0;
  // kind 0 command, 1 failed txn, 2 write error; one cycle each
  task send(input [1:0] kind, input [12:0] q, input [35:0] a);
    begin
      @(negedge sys_clk_i);
      qual_o = q;
      addr_o = a;
      {txn_valid_o, txn_err_o, mwr_err_o} = {kind == 2'h0, kind == 2'h1, kind == 2'h2};
      @(negedge sys_clk_i);
      {txn_valid_o, txn_err_o, mwr_err_o} = 3'h0;
      // qualifiers no longer held: show the inverse, not the old value
      qual_o = ~q;
      addr_o = ~a;
    end
  endtask
  task set_mirq(input v);
    begin
      @(negedge sys_clk_i);
      mirq_o = v;
    end
  endtask
endmodule // pmes_slave_model

// ### tb/pmes_regs_tb.sv
`timescale 1ns/1ps
`include "pmes_defs.vh"
module pmes_regs_tb;
  reg sys_clk_i, reset_i, rd, wr;
  reg [`PMES_AW-1:0] addr;
  reg [31:0] wdata, d;
  reg [5:0] qev;
  reg [18:0] t;
  wire ack, tv, te, we, mq, wpost, qirq;
  wire [31:0] rdata;
  wire [12:0] q;
  wire [35:0] ta;
  wire [1:0] flush;
  wire [6:0] qclr;
  integer n_errors, n_compared, i;
  // entries {mid, slave port, fabric id, expected status}
  localparam [9*19-1:0] MW_TAB = {3'h0, 3'h0, 13'h0400, 3'h1, 3'h0, 13'h0200, 3'h2, 3'h0,
    13'h0100, 3'h3, 3'h0, 13'h1000, 3'h4, 3'h0, 13'h0800, 3'h3, 3'h4, 13'h0080,
    3'h3, 3'h7, 13'h0010, 3'h4, 3'h4, 13'h0008, 3'h4, 3'h7, 13'h0001};
  // size f, read, requester 4, slave port, fabric id 3, slave size 3
  localparam [12:0] Q_ALL = 13'h1f9f;
  pmes_slave_model i_slv (.sys_clk_i(sys_clk_i), .txn_valid_o(tv), .txn_err_o(te),
    .mwr_err_o(we), .mirq_o(mq), .qual_o(q), .addr_o(ta));
  pmes_regs i_dut (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .dcr_rd_i(rd), .dcr_wr_i(wr),
    .dcr_addr_i(addr), .dcr_wdata_i(wdata), .dcr_ack_o(ack), .dcr_rdata_o(rdata),
    .txn_valid_i(tv), .txn_size_i(q[12:9]), .txn_rnw_i(q[8]), .txn_mid_i(q[7:5]),
    .txn_slave_port_i(q[4]), .txn_fmid_i(q[3:2]), .txn_ssize_i(q[1:0]), .txn_type_i(3'h0),
    .txn_lockerr_i(1'b0), .txn_be_i(ta[15:0]), .txn_addr_i(ta), .txn_err_i(te),
    .slave_mwr_err_i(we), .slave_mirq_i(mq), .queue_event_i(qev), .flush_mode_o(flush),
    .write_post_o(wpost), .queue_clear_o(qclr), .xbar_queue_irq_o(qirq));
  initial begin
    sys_clk_i = 1'b0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end
  task chk(input [31:0] g, input [31:0] e);
    begin
      n_compared = n_compared + 1;
      if (g !== e) begin
        n_errors = n_errors + 1;
        $display("Error at %0t: got %h expected %h", $time, g, e);
      end
    end
  endtask
  // one access; strobe dropped in the ack cycle, bounded wait
  task dcr(input w, input [`PMES_AW-1:0] a, input [31:0] v);
    integer k;
    begin
      @(negedge sys_clk_i);
      {wr, rd, addr, wdata} = {w, !w, a, v};
      k = 0;
      while (ack !== 1'b1 && k < 20) begin
        @(negedge sys_clk_i);
        k = k + 1;
      end
      chk({31'h0, ack}, 32'h1);
      d = rdata;
      {wr, rd} = 2'h0;
    end
  endtask
  task rdc(input [`PMES_AW-1:0] a, input [31:0] m, input [31:0] e);
    begin
      dcr(1'b0, a, 32'h0);
      chk(d & m, e);
    end
  endtask
  task ev(input [5:0] v);
    begin
      @(negedge sys_clk_i);
      qev = v;
      @(negedge sys_clk_i);
      qev = 6'h0;
    end
  endtask
  task wrap_up;
    begin
      $display("compared %0d mismatches %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask
  initial begin
    #60000;
    n_errors = n_errors + 1;
    wrap_up;
  end
  initial begin
    {reset_i, rd, wr, addr, wdata, qev, n_errors, n_compared} = {1'b1, 50'h0, 64'h0};
    repeat (8) @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    reset_i = 1'b0;
    rdc(`PMES_A_CFG, 32'hffffffff, `PMES_CFG_RST);
    chk({31'h0, wpost}, 32'h1);
    for (i = 'h55; i <= 'h5e; i = i + 1) rdc(i[9:0], 32'hffffffff, 32'h0);
    rdc(10'h3ff, 32'hffffffff, 32'h0);
    $display("reset values done");
    dcr(1'b1, `PMES_A_SNIFF, 32'hffffffff);
    rdc(`PMES_A_SNIFF, 32'hffffffff, 32'h8ffbc07f);
    dcr(1'b1, `PMES_A_SNIFFA, 32'ha5a53c3c);
    rdc(`PMES_A_SNIFFA, 32'hffffffff, 32'ha5a53c3c);
    dcr(1'b1, `PMES_A_FSM, 32'hffffffff);
    rdc(`PMES_A_FSM, 32'hffffffff, 32'h0);
    dcr(1'b1, `PMES_A_MCTRL, 32'hffffffff);
    chk({25'h0, qclr}, 32'h7f);
    chk({30'h0, flush}, 32'h3);
    rdc(`PMES_A_MCTRL, 32'hffffffff, 32'h70000000);
    dcr(1'b1, `PMES_A_MCTRL, 32'h0);
    chk({30'h0, flush}, 32'h0);
    dcr(1'b1, `PMES_A_MCTRL, 32'h00000040);
    chk({25'h0, qclr}, 32'h40);
    $display("register access done");
    for (i = 0; i < 6; i = i + 1) begin
      ev(6'h1 << i);
      rdc(`PMES_A_QFLAGS, 32'hffffffff, 32'h1 << i);
      chk({31'h0, qirq}, 32'h1);
      dcr(1'b1, `PMES_A_QFLAGS, ~(32'h1 << i));
      rdc(`PMES_A_QFLAGS, 32'hffffffff, 32'h1 << i);
      dcr(1'b1, `PMES_A_QFLAGS, 32'h1 << i);
      rdc(`PMES_A_QFLAGS, 32'hffffffff, 32'h0);
      chk({31'h0, qirq}, 32'h0);
    end
    $display("queue flags done");
    i_slv.set_mirq(1'b1);
    rdc(`PMES_A_IRQ, 32'hffffffff, 32'h1fff);
    dcr(1'b1, `PMES_A_IRQ, 32'h1fff);
    rdc(`PMES_A_IRQ, 32'hffffffff, 32'h1fff);
    i_slv.set_mirq(1'b0);
    rdc(`PMES_A_IRQ, 32'hffffffff, 32'h0);
    for (i = 0; i < 9; i = i + 1) begin
      t = MW_TAB[i*19 +: 19];
      i_slv.send(2'h2, {5'h0, t[18:16], t[15], t[14:13], 2'h0}, 36'h0);
      rdc(`PMES_A_IRQ, 32'hffffffff, {19'h0, t[12:0]});
      dcr(1'b1, `PMES_A_IRQ, {19'h0, t[12:0]});
      rdc(`PMES_A_IRQ, 32'hffffffff, 32'h0);
    end
    dcr(1'b1, `PMES_A_CFG, 32'h0000009d);
    chk({31'h0, wpost}, 32'h0);
    i_slv.send(2'h2, 13'h0020, 36'h0);
    rdc(`PMES_A_IRQ, 32'hffffffff, 32'h0);
    $display("mirq done");
    dcr(1'b1, `PMES_A_ESTAT, 32'h0);
    dcr(1'b1, `PMES_A_SNIFF, 32'h0);
    i_slv.send(2'h0, Q_ALL, 36'h0);
    rdc(`PMES_A_ESTAT, 32'h80000000, 32'h0);
    for (i = 0; i < 7; i = i + 1) begin
      dcr(1'b1, `PMES_A_SNIFF, 32'h80000000 | (32'h40 >> i));
      i_slv.send(2'h0, Q_ALL, 36'h0);
      rdc(`PMES_A_ESTAT, 32'h80000000, 32'h0);
    end
    dcr(1'b1, `PMES_A_SNIFF, 32'h80000000);
    i_slv.send(2'h0, Q_ALL, 36'h9a5a53c3c);
    rdc(`PMES_A_ESTAT, 32'h80000000, 32'h80000000);
    rdc(`PMES_A_EADDR_LO, 32'hffffffff, 32'ha5a53c3c);
    rdc(`PMES_A_EADDR_HI, 32'hf, 32'h9);
    dcr(1'b1, `PMES_A_ESTAT, 32'h0);
    dcr(1'b1, `PMES_A_SNIFF, 32'h80000001);
    i_slv.send(2'h0, Q_ALL, 36'h9a5a53c3d);
    rdc(`PMES_A_ESTAT, 32'h80000000, 32'h0);
    i_slv.send(2'h0, Q_ALL, 36'h9a5a53c3c);
    rdc(`PMES_A_ESTAT, 32'h80000000, 32'h80000000);
    dcr(1'b1, `PMES_A_ESTAT, 32'h0);
    dcr(1'b1, `PMES_A_SNIFF, 32'h8fcbc07f);
    i_slv.send(2'h0, Q_ALL, 36'h9a5a53c3c);
    rdc(`PMES_A_ESTAT, 32'hffffffff, 32'hb31f3c3c);
    dcr(1'b1, `PMES_A_CFG, `PMES_CFG_RST);
    dcr(1'b1, `PMES_A_SNIFF, 32'h80000000);
    i_slv.send(2'h0, Q_ALL, 36'h111111111);
    rdc(`PMES_A_EADDR_LO, 32'hffffffff, 32'ha5a53c3c);
    $display("sniffer done");
    wrap_up;
  end
endmodule // pmes_regs_tb
